// *** flc_ctrl.sv ***
// host-side command controller for a parallel nor flash, with an ahb-lite register port
// Function
// - write needs chip select, write low, oe high
// - address at later fall, data earlier rise
// - bad sequence must be followed by reset
// - time limit error needs a reset write
// - unlock, unlock, autoselect enters autoselect mode
// - program is four cycles, width follows pin
// - unlock, unlock, 20h enters bypass; A0h programs
// - bypass accepts program and 90h/00h exit
// - 98h at 55h/AAh enters query mode
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
module flc_ctrl import flc_pkg::*; (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	// flash pins
	output flc_pins_s        flash_o,
	input  wire logic [15:0] flash_dq_i,
	input  wire logic        flash_ready_busy_i,
	input  wire logic        flash_supply_low_i
);

	typedef struct packed {
		flc_state_e  st;
		logic [3:0]  op;
		logic [1:0]  step;
		flc_mode_e   mode;
		logic        byte_mode;
		logic [20:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        err;
		logic        refused;
		logic        poll_second;
		logic        dp_valid;
		logic        dp_write;
		logic [5:0]  dp_idx;
	} flc_ctrl_s;

	flc_ctrl_s   s_reg;
	flc_ctrl_s   s_next;
	flc_cyc_s    seq_cyc;
	flc_cyc_s    bus_cyc;
	logic        bus_start;
	logic        bus_done;
	logic [15:0] bus_rdata;

	// cycle table per operation; unlock addresses depend on the width pin
	function automatic flc_cyc_s seq_cycle(input logic [3:0] op, input logic [1:0] step,
	                                       input logic bm, input logic [20:0] a, input logic [15:0] d);
		flc_cyc_s    c;
		logic [20:0] u2;
		u2     = bm ? UNLK2_BYTE : UNLK2_WORD;
		c      = '{rd: 1'b0, last: 1'b0, addr: (bm ? UNLK1_BYTE : UNLK1_WORD), data: UNLK1_DATA};
		case (op)
			OP_READ: c = '{rd: 1'b1, last: 1'b1, addr: a, data: RST_DATA};
			OP_RESET: begin
				c.data = CMD_RESET;
				c.last = 1'b1;
			end
			OP_QUERY: begin
				c.addr = bm ? QRY_BYTE : QRY_WORD;
				c.data = CMD_QUERY;
				c.last = 1'b1;
			end
			OP_AUTOSEL, OP_PROGRAM, OP_BYP_ENTER: begin
				case (step)
					2'd0: c.data = UNLK1_DATA;
					2'd1: begin
						c.addr = u2;
						c.data = UNLK2_DATA;
					end
					2'd2: begin
						c.data = (op == OP_AUTOSEL) ? CMD_AUTOSEL :
						         (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_BYPASS;
						c.last = (op != OP_PROGRAM);
					end
					default: begin
						c.addr = a;
						c.data = d;
						c.last = 1'b1;
					end
				endcase
			end
			OP_BYP_PROGRAM: begin
				if (step == 2'd0) begin
					c.data = CMD_PROGRAM;
				end else begin
					c.addr = a;
					c.data = d;
					c.last = 1'b1;
				end
			end
			OP_BYP_EXIT: begin
				c.data = (step == 2'd0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
				c.last = (step != 2'd0);
			end
			default: c.last = 1'b1;
		endcase
		return c;
	endfunction

	// which operations the device mode allows; bypass admits only reads and its own program and exit
	function automatic logic op_allowed(input logic [3:0] op, input flc_mode_e m);
		logic ok;
		ok = 1'b0;
		case (op)
			OP_READ:        ok = 1'b1;
			OP_RESET:       ok = (m != MODE_BYPASS);
			OP_QUERY:       ok = (m == MODE_READ) || (m == MODE_AUTO);
			OP_AUTOSEL:     ok = (m == MODE_READ);
			OP_PROGRAM:     ok = (m == MODE_READ);
			OP_BYP_ENTER:   ok = (m == MODE_READ);
			OP_BYP_PROGRAM: ok = (m == MODE_BYPASS);
			OP_BYP_EXIT:    ok = (m == MODE_BYPASS);
			default:        ok = 1'b0;
		endcase
		return ok;
	endfunction

	assign seq_cyc   = seq_cycle(s_reg.op, s_reg.step, s_reg.byte_mode, s_reg.addr, s_reg.wdata);
	assign bus_start = (s_reg.st == ST_ISSUE) || (s_reg.st == ST_PISSUE);
	// status polling reads the programmed address itself
	assign bus_cyc   = (s_reg.st == ST_PISSUE) ?
	                   flc_cyc_s'{rd: 1'b1, last: 1'b1, addr: s_reg.addr, data: RST_DATA} : seq_cyc;

	// register port, operation sequencer and polling
	always_comb begin
		s_next          = s_reg;
		s_next.dp_valid = hsel_i && htrans_i[1] && hready_i;
		if (s_next.dp_valid) begin
			s_next.dp_write = hwrite_i;
			s_next.dp_idx   = haddr_i[7:2];
		end
		// software writes first, so hardware events below win over a clear
		if (s_reg.dp_valid && s_reg.dp_write) begin
			case (s_reg.dp_idx)
				REG_CTRL: begin
					// a busy or lockout controller ignores the order; the device would too
					if (s_reg.st == ST_IDLE && !flash_supply_low_i &&
					    op_allowed(hwdata_i[3:0], s_reg.mode)) begin
						s_next.op          = hwdata_i[3:0];
						s_next.step        = 2'd0;
						s_next.poll_second = 1'b0;
						s_next.st          = ST_ISSUE;
					end else begin
						s_next.refused = 1'b1;
					end
				end
				REG_CFG: begin
					if (s_reg.st == ST_IDLE) begin
						s_next.byte_mode = hwdata_i[0];
					end
				end
				REG_ADDR: if (s_reg.st == ST_IDLE) s_next.addr = hwdata_i[20:0];
				REG_WDATA: if (s_reg.st == ST_IDLE) s_next.wdata = hwdata_i[15:0];
				REG_STATUS: begin
					if (hwdata_i[STAT_ERR]) s_next.err = 1'b0;
					if (hwdata_i[STAT_REFUSED]) s_next.refused = 1'b0;
				end
				default: ;
			endcase
		end
		case (s_reg.st)
			ST_IDLE: ;
			ST_ISSUE: s_next.st = ST_WAIT;
			ST_WAIT: begin
				if (bus_done) begin
					if (seq_cyc.rd) begin
						s_next.rdata = bus_rdata;
					end
					if (!seq_cyc.last) begin
						s_next.step = s_reg.step + 2'd1;
						s_next.st   = ST_ISSUE;
					end else begin
						s_next.st = ST_IDLE;
						case (s_reg.op)
							OP_RESET:       s_next.mode = MODE_READ;
							OP_AUTOSEL:     s_next.mode = MODE_AUTO;
							OP_QUERY:       s_next.mode = MODE_QUERY;
							OP_BYP_ENTER:   s_next.mode = MODE_BYPASS;
							OP_BYP_EXIT:    s_next.mode = MODE_READ;
							OP_PROGRAM, OP_BYP_PROGRAM: s_next.st = ST_PISSUE;
							default: ;
						endcase
					end
				end
			end
			ST_PISSUE: s_next.st = ST_PWAIT;
			ST_PWAIT: begin
				if (bus_done) begin
					s_next.rdata = bus_rdata;
					if (bus_rdata[POLLING_BIT] == s_reg.wdata[POLLING_BIT]) begin
						s_next.st   = ST_IDLE;
						s_next.mode = (s_reg.op == OP_BYP_PROGRAM) ? MODE_BYPASS : MODE_READ;
					end else if (s_reg.poll_second) begin
						// failed program: reset brings the device back to array read
						s_next.err  = 1'b1;
						s_next.op   = OP_RESET;
						s_next.step = 2'd0;
						s_next.st   = ST_ISSUE;
					end else begin
						s_next.poll_second = bus_rdata[TIME_LIMIT_BIT];
						s_next.st          = ST_PISSUE;
					end
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
	end

	// device starts in array read after its own power-up reset
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_reg <= '{st: ST_IDLE, op: OP_READ, step: 2'd0, mode: MODE_READ,
			           byte_mode: RST_BYTE_MODE, addr: RST_ADDR, wdata: RST_DATA,
			           rdata: RST_DATA, err: 1'b0, refused: 1'b0, poll_second: 1'b0,
			           dp_valid: 1'b0, dp_write: 1'b0, dp_idx: 6'h00};
		end else begin
			s_reg <= s_next;
		end
	end

	// zero-wait slave; read data muxed in the data phase so a write just before is seen
	always_comb begin
		hrdata_o = 32'h0000_0000;
		if (s_reg.dp_valid && !s_reg.dp_write) begin
			case (s_reg.dp_idx)
				REG_CTRL:   hrdata_o = {28'h000_0000, s_reg.op};
				REG_CFG:    hrdata_o = {31'h0000_0000, s_reg.byte_mode};
				REG_ADDR:   hrdata_o = {11'h000, s_reg.addr};
				REG_WDATA:  hrdata_o = {16'h0000, s_reg.wdata};
				REG_RDATA:  hrdata_o = {16'h0000, s_reg.rdata};
				REG_STATUS: begin
					hrdata_o[STAT_BUSY]                   = (s_reg.st != ST_IDLE);
					hrdata_o[STAT_ERR]                    = s_reg.err;
					hrdata_o[STAT_RDY]                    = flash_ready_busy_i;
					hrdata_o[STAT_MODE_LO +: 2]           = s_reg.mode;
					hrdata_o[STAT_REFUSED]                = s_reg.refused;
					hrdata_o[STAT_LOCKOUT]                = flash_supply_low_i;
				end
				default:    hrdata_o = 32'h0000_0000;
			endcase
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	flc_bus_cycle u_bus_cycle (
		.ref_clk_i   (ref_clk_i),
		.reset_i     (reset_i),
		.start_i     (bus_start),
		.cyc_i       (bus_cyc),
		.byte_mode_i (s_reg.byte_mode),
		.done_o      (bus_done),
		.rdata_o     (bus_rdata),
		.dq_i        (flash_dq_i),
		.pins_o      (flash_o)
	);

endmodule // flc_ctrl

// *** flc_pkg.sv ***
// shared constants, types and device map for the flash command controller
package flc_pkg;

	// controller register word indices (byte address = index * 4)
	localparam logic [5:0]  REG_CTRL        = 6'h00;
	localparam logic [5:0]  REG_CFG         = 6'h01;
	localparam logic [5:0]  REG_ADDR        = 6'h02;
	localparam logic [5:0]  REG_WDATA       = 6'h03;
	localparam logic [5:0]  REG_RDATA       = 6'h04;
	localparam logic [5:0]  REG_STATUS      = 6'h05;

	// status field positions
	localparam int          STAT_BUSY       = 0;
	localparam int          STAT_ERR        = 1;
	localparam int          STAT_RDY        = 2;
	localparam int          STAT_MODE_LO    = 4;
	localparam int          STAT_REFUSED    = 7;
	localparam int          STAT_LOCKOUT    = 8;

	// reset values
	localparam logic        RST_BYTE_MODE   = 1'b0;
	localparam logic [20:0] RST_ADDR        = 21'h00_0000;
	localparam logic [15:0] RST_DATA        = 16'h0000;

	// operations written to the control register
	localparam logic [3:0]  OP_READ         = 4'h0;
	localparam logic [3:0]  OP_RESET        = 4'h1;
	localparam logic [3:0]  OP_AUTOSEL      = 4'h2;
	localparam logic [3:0]  OP_QUERY        = 4'h3;
	localparam logic [3:0]  OP_PROGRAM      = 4'h4;
	localparam logic [3:0]  OP_BYP_ENTER    = 4'h5;
	localparam logic [3:0]  OP_BYP_PROGRAM  = 4'h6;
	localparam logic [3:0]  OP_BYP_EXIT     = 4'h7;

	// device command cycles
	localparam logic [20:0] UNLK1_WORD      = 21'h00_0555;
	localparam logic [20:0] UNLK2_WORD      = 21'h00_02AA;
	localparam logic [20:0] UNLK1_BYTE      = 21'h00_0AAA;
	localparam logic [20:0] UNLK2_BYTE      = 21'h00_0555;
	localparam logic [20:0] QRY_WORD        = 21'h00_0055;
	localparam logic [20:0] QRY_BYTE        = 21'h00_00AA;
	localparam logic [15:0] UNLK1_DATA      = 16'h00AA;
	localparam logic [15:0] UNLK2_DATA      = 16'h0055;
	localparam logic [15:0] CMD_RESET       = 16'h00F0;
	localparam logic [15:0] CMD_AUTOSEL     = 16'h0090;
	localparam logic [15:0] CMD_PROGRAM     = 16'h00A0;
	localparam logic [15:0] CMD_BYPASS      = 16'h0020;
	localparam logic [15:0] CMD_QUERY       = 16'h0098;
	localparam logic [15:0] CMD_BYP_EXIT1   = 16'h0090;
	localparam logic [15:0] CMD_BYP_EXIT2   = 16'h0000;

	// status bits read back while programming
	localparam int          POLLING_BIT     = 7;
	localparam int          TIME_LIMIT_BIT  = 5;

	// expected extended query words at word offsets 40h..4Ch
	localparam logic [7:0]  EXT_QUERY_BASE  = 8'h40;
	localparam logic [15:0] EXT_QUERY [13]  = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033,
	                                            16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0004,
	                                            16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] PROT_YES        = 16'h0001;
	localparam logic [15:0] PROT_NO         = 16'h0000;

	// pin timing, in ns and in clock cycles at 8 ns
	localparam int          CLK_NS          = 8;
	localparam int          T_SETUP_NS      = 8;
	localparam int          T_PULSE_NS      = 40;
	localparam int          T_READ_NS       = 80;
	localparam int          T_HOLD_NS       = 16;
	localparam logic [3:0]  SETUP_CYC       = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  PULSE_CYC       = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  READ_CYC        = 4'((T_READ_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  HOLD_CYC        = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ISSUE  = 3'b001,
		ST_WAIT   = 3'b011,
		ST_PISSUE = 3'b010,
		ST_PWAIT  = 3'b110
	} flc_state_e;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_SETUP = 2'b01,
		PH_PULSE = 2'b11,
		PH_HOLD  = 2'b10
	} flc_phase_e;

	typedef enum logic [1:0] {
		MODE_READ   = 2'b00,
		MODE_AUTO   = 2'b01,
		MODE_QUERY  = 2'b11,
		MODE_BYPASS = 2'b10
	} flc_mode_e;

	// one pin cycle to perform
	typedef struct packed {
		logic        rd;
		logic        last;
		logic [20:0] addr;
		logic [15:0] data;
	} flc_cyc_s;

	// flash pins driven by the controller
	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic        word_mode;
		logic [20:0] addr;
		logic [15:0] dq;
		logic        dq_oe;
	} flc_pins_s;

endpackage

// *** flc_bus_cycle.sv ***
// single timed read or write cycle on the flash pins
module flc_bus_cycle import flc_pkg::*; (
	// clock and reset
	input  wire logic      ref_clk_i,
	input  wire logic      reset_i,
	// request
	input  wire logic      start_i,
	input  wire flc_cyc_s  cyc_i,
	input  wire logic      byte_mode_i,
	// answer
	output logic           done_o,
	output logic [15:0]    rdata_o,
	// pins
	input  wire logic [15:0] dq_i,
	output flc_pins_s      pins_o
);

	typedef struct packed {
		flc_phase_e  ph;
		logic [3:0]  cnt;
		flc_cyc_s    cyc;
		logic [15:0] rdata;
		logic        done;
	} flc_bc_s;

	flc_bc_s s_reg;
	flc_bc_s s_next;

	// phase sequencing; address stands from setup so both strobes fall onto a settled bus
	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		case (s_reg.ph)
			PH_IDLE: begin
				if (start_i) begin
					s_next.cyc = cyc_i;
					s_next.ph  = PH_SETUP;
					s_next.cnt = SETUP_CYC - 4'h1;
				end
			end
			PH_SETUP: begin
				if (s_reg.cnt == 4'h0) begin
					s_next.ph  = PH_PULSE;
					s_next.cnt = (s_reg.cyc.rd ? READ_CYC : PULSE_CYC) - 4'h1;
				end else begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			PH_PULSE: begin
				if (s_reg.cnt == 4'h0) begin
					if (s_reg.cyc.rd) begin
						s_next.rdata = dq_i;
					end
					s_next.ph  = PH_HOLD;
					s_next.cnt = HOLD_CYC - 4'h1;
				end else begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			PH_HOLD: begin
				if (s_reg.cnt == 4'h0) begin
					s_next.ph   = PH_IDLE;
					s_next.done = 1'b1;
				end else begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			default: s_next.ph = PH_IDLE;
		endcase
	end

	// strobes idle high from reset, so no write can be seen at power-up
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_reg <= '{ph: PH_IDLE, cnt: 4'h0, cyc: '0, rdata: RST_DATA, done: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// write: chip select and write strobe low together, output enable high throughout
	always_comb begin
		pins_o.ce_n      = !(s_reg.ph == PH_PULSE);
		pins_o.we_n      = !(s_reg.ph == PH_PULSE && !s_reg.cyc.rd);
		pins_o.oe_n      = !(s_reg.ph == PH_PULSE && s_reg.cyc.rd);
		pins_o.word_mode = !byte_mode_i;
		pins_o.addr      = s_reg.cyc.addr;
		pins_o.dq        = s_reg.cyc.data;
		pins_o.dq_oe     = (s_reg.ph != PH_IDLE) && !s_reg.cyc.rd;
	end

	assign done_o  = s_reg.done;
	assign rdata_o = s_reg.rdata;

endmodule // flc_bus_cycle

// *** flc_ctrl_assertions.sv ***
// pin-level checks for the flash command controller
module flc_ctrl_assertions import flc_pkg::*; (
	// clock and reset
	input wire logic      ref_clk_i,
	input wire logic      reset_i,
	// watched ports
	input wire flc_pins_s flash_o,
	input wire logic      flash_supply_low_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// strobe pulse shapes: five clocks of write, ten of read
	sequence s_wr;
		!flash_o.we_n [*5] ##1 flash_o.we_n;
	endsequence
	sequence s_rd;
		!flash_o.oe_n [*8] ##1 !flash_o.oe_n [*2] ##1 flash_o.oe_n;
	endsequence

	property p_wr_qual;
		!flash_o.we_n |-> !flash_o.ce_n && flash_o.oe_n;
	endproperty
	a_wr_qual: assert property (p_wr_qual) else $error("write strobe not qualified");
	property p_rd_quiet;
		!flash_o.oe_n |-> flash_o.we_n && !flash_o.ce_n && !flash_o.dq_oe;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read overlaps a write");
	property p_reset_idle;
		$fell(reset_i) |-> flash_o.ce_n && flash_o.we_n && flash_o.oe_n && !flash_o.dq_oe && flash_o.word_mode;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
	property p_wr_pulse;
		$fell(flash_o.we_n) |-> s_wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length wrong");
	property p_rd_pulse;
		$fell(flash_o.oe_n) |-> s_rd;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse length wrong");
	property p_wr_hold;
		$fell(flash_o.we_n) |-> ($stable(flash_o.addr) && $stable(flash_o.dq) && flash_o.dq_oe) [*7];
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("address or data moved in write");
	property p_dq_release;
		$rose(flash_o.we_n) |-> ##2 !flash_o.dq_oe;
	endproperty
	a_dq_release: assert property (p_dq_release) else $error("data bus not released");
	// gaps inside an operation are shorter than eight clocks
	property p_lockout;
		(flash_supply_low_i && flash_o.ce_n) [*8] |=> flash_o.ce_n;
	endproperty
	a_lockout: assert property (p_lockout) else $error("operation started in lockout");
endmodule // flc_ctrl_assertions

bind flc_ctrl flc_ctrl_assertions u_chk (
	.ref_clk_i          (ref_clk_i),
	.reset_i            (reset_i),
	.flash_o            (flash_o),
	.flash_supply_low_i (flash_supply_low_i)
);

// *** flc_flash_model.sv ***
// behavioural parallel nor flash answering the controller's pins
module flc_flash_model import flc_pkg::*; #(
	parameter int          PROG_NS  = 400,
	parameter logic [15:0] MFR_CODE = 16'h005A, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h00C3  // arbitrary value
) (
	// pins from the controller, plus the supply-low and fail inputs
	input  wire flc_pins_s   pins_i,
	input  wire logic        supply_low_i,
	input  wire logic        fail_i,
	// answer to the controller
	output logic [15:0]      dq_o,
	output logic             ready_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	logic [15:0] pd;
	logic [15:0] held;
	logic [7:0]  pa;
	logic [20:0] la;
	flc_mode_e   mode;
	int          step;
	logic        busy;
	logic        err;
	logic        tog;
	wire logic   wm = pins_i.word_mode;
	wire logic   wr = !pins_i.ce_n && !pins_i.we_n && pins_i.oe_n && !supply_low_i;
	wire logic   rd = !pins_i.ce_n && !pins_i.oe_n;

	// power-up: erased array, array read, ready
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		mode = MODE_READ;
		step = 0;
		busy = 1'b0;
		err = 1'b0;
		tog = 1'b0;
		held = 16'h0000;
		ready_busy_o = 1'b1;
	end
	// low supply drops any half-written sequence
	always @(posedge supply_low_i) begin
		mode = MODE_READ;
		step = 0;
	end
	// address on the later fall, data on the earlier rise
	always @(posedge wr) la = pins_i.addr;
	always @(negedge wr) cmd(la, pins_i.dq);

	task automatic cmd(input logic [20:0] a, input logic [15:0] d);
		logic [20:0] u1;
		logic [20:0] u2;
		u1 = wm ? UNLK1_WORD : UNLK1_BYTE;
		u2 = wm ? UNLK2_WORD : UNLK2_BYTE;
		if (busy) begin
			// while busy only the reset after a time-limit fault counts
			if (err && d == CMD_RESET) begin
				busy = 1'b0;
				err = 1'b0;
				ready_busy_o = 1'b1;
				mode = MODE_READ;
			end
		end else if (d == CMD_RESET && mode != MODE_BYPASS) begin
			mode = MODE_READ;
			step = 0;
		end else if (step == 3) begin
			pa = a[7:0];
			pd = d;
			err = fail_i;
			ready_busy_o = 1'b0;
			busy = 1'b1;
			step = 0;
		end else if (mode == MODE_BYPASS) begin
			if (step == 5 && d == CMD_BYP_EXIT2) mode = MODE_READ;
			step = (step == 0 && d == CMD_PROGRAM) ? 3 : (step == 0 && d == CMD_BYP_EXIT1) ? 5 : 0;
		end else if (step == 0 && a == (wm ? QRY_WORD : QRY_BYTE) && d == CMD_QUERY) begin
			mode = MODE_QUERY;
		end else if (step == 0) begin
			step = (a == u1 && d == UNLK1_DATA) ? 1 : 0;
		end else if (step == 1) begin
			step = (a == u2 && d == UNLK2_DATA) ? 2 : 0;
		end else begin
			if (a == u1 && d == CMD_AUTOSEL) mode = MODE_AUTO;
			if (a == u1 && d == CMD_BYPASS) mode = MODE_BYPASS;
			step = (a == u1 && d == CMD_PROGRAM) ? 3 : 0;
		end
	endtask

	// program algorithm; a time-limit fault never completes on its own
	always @(posedge busy) begin
		#(PROG_NS);
		if (busy && !err) begin
			mem[pa] = mem[pa] & pd;
			busy = 1'b0;
			ready_busy_o = 1'b1;
		end
	end

	function automatic logic [15:0] rval(input logic [20:0] a, input flc_mode_e m, input logic b, input logic t);
		logic [7:0] q;
		q = wm ? a[7:0] : a[8:1];
		if (b) return {8'h00, ~pd[7], t, err, 5'h00};
		if (m == MODE_AUTO) begin
			if (a[7:0] == 8'h00) return MFR_CODE;
			if (a[7:0] == 8'h01) return DEV_CODE;
			if (a[7:0] == (wm ? 8'h02 : 8'h04)) return a[20] ? PROT_YES : PROT_NO;
			return 16'h0000;
		end
		if (m == MODE_QUERY) return (q >= 8'h40 && q <= 8'h4C) ? EXT_QUERY[q - 8'h40] : 16'h0000;
		return mem[a[7:0]];
	endfunction

	assign dq_o = rd ? rval(pins_i.addr, mode, busy, tog) : held;
	// a released bus shows the inverse of the last value, never a stale copy
	always @(posedge rd) begin
		tog = busy ? ~tog : tog;
		#1 held = ~dq_o;
	end
endmodule // flc_flash_model

// *** flc_ctrl_tb.sv ***
// self-checking bench for the flash command controller
module flc_ctrl_tb import flc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        bm;
		logic [3:0]  op;
		logic [20:0] a;
		logic [15:0] e;
	} flc_row_s;
	localparam logic [15:0] MFR = 16'h005A; // arbitrary value
	localparam logic [15:0] DEV = 16'h00C3; // arbitrary value
	// byte mode, entry op, read address, expected word
	localparam flc_row_s ROWS [20] = '{
		'{1'b0, OP_QUERY, 21'h40, 16'h0050}, '{1'b0, OP_QUERY, 21'h41, 16'h0052}, '{1'b0, OP_QUERY, 21'h42, 16'h0049},
		'{1'b0, OP_QUERY, 21'h43, 16'h0031}, '{1'b0, OP_QUERY, 21'h44, 16'h0033}, '{1'b0, OP_QUERY, 21'h45, 16'h0008},
		'{1'b0, OP_QUERY, 21'h46, 16'h0002}, '{1'b0, OP_QUERY, 21'h47, 16'h0001}, '{1'b0, OP_QUERY, 21'h48, 16'h0001},
		'{1'b0, OP_QUERY, 21'h49, 16'h0004}, '{1'b0, OP_QUERY, 21'h4A, 16'h0000}, '{1'b0, OP_QUERY, 21'h4B, 16'h0000},
		'{1'b0, OP_QUERY, 21'h4C, 16'h0000}, '{1'b1, OP_QUERY, 21'h8A, 16'h0008}, '{1'b1, OP_QUERY, 21'h98, 16'h0000},
		'{1'b0, OP_AUTOSEL, 21'h0, MFR}, '{1'b0, OP_AUTOSEL, 21'h1, DEV}, '{1'b0, OP_AUTOSEL, 21'h10_0002, 16'h0001},
		'{1'b0, OP_AUTOSEL, 21'h2, 16'h0000}, '{1'b1, OP_AUTOSEL, 21'h10_0004, 16'h0001}
	};
	logic        ref_clk_i;
	logic        reset_i    = 1'b1;
	logic        hsel_i     = 1'b0;
	logic        hwrite_i   = 1'b0;
	logic        supply_low = 1'b0;
	logic        fail       = 1'b0;
	logic [1:0]  htrans_i   = 2'b00;
	logic [2:0]  hsize_i    = 3'h2;
	logic [31:0] haddr_i    = 32'h0000_0000;
	logic [31:0] hwdata_i   = 32'h0000_0000;
	logic [31:0] rv;
	wire logic   hready;
	wire logic   hresp;
	wire logic [31:0] hrdata;
	wire logic [15:0] mdq;
	wire logic [15:0] dq;
	wire logic   rb;
	flc_pins_s   flash;
	int          err_total  = 0;
	int          cmp_count  = 0;
	int          cyc        = 0;

	// the controller drives the data wire only while its enable is high
	assign dq = flash.dq_oe ? flash.dq : mdq;

	flc_ctrl u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .flash_o(flash), .flash_dq_i(dq),
		.flash_ready_busy_i(rb), .flash_supply_low_i(supply_low));
	flc_flash_model #(.PROG_NS(400), .MFR_CODE(MFR), .DEV_CODE(DEV)) u_mem (.pins_i(flash),
		.supply_low_i(supply_low), .fail_i(fail), .dq_o(mdq), .ready_busy_o(rb));

	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	// hang guard, far above the few thousand clocks the run needs
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("mismatches=%0d comparisons=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one single ahb-lite transfer; read data taken at the data-phase edge
	task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= {24'h00_0000, idx, 2'b00};
		hwrite_i <= w;
		@(posedge ref_clk_i);
		while (hready !== 1'b1) @(posedge ref_clk_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= wd;
		@(posedge ref_clk_i);
		while (hready !== 1'b1) @(posedge ref_clk_i);
		rv = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// address and data first, then the op, then poll busy down
	task automatic run_op(input logic [3:0] o, input logic [20:0] a, input logic [15:0] d);
		ahb(1'b1, REG_ADDR, {11'h000, a});
		ahb(1'b1, REG_WDATA, {16'h0000, d});
		ahb(1'b1, REG_CTRL, {28'h000_0000, o});
		ahb(1'b0, REG_STATUS, '0);
		while (rv[STAT_BUSY] !== 1'b0) ahb(1'b0, REG_STATUS, '0);
	endtask
	task automatic chk_arr(input logic [20:0] a, input logic [15:0] e);
		run_op(OP_READ, a, '0);
		ahb(1'b0, REG_RDATA, '0);
		chk(rv, {16'h0000, e});
	endtask
	task automatic chk_st(input logic [31:0] e);
		ahb(1'b0, REG_STATUS, '0);
		chk(rv, e);
	endtask

	initial begin
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk({29'h0, flash.ce_n, flash.we_n, flash.oe_n}, 32'h0000_0007);
		chk({30'h0, hready, hresp}, 32'h0000_0002);
		chk_st(32'h0000_0004);
		ahb(1'b0, 6'h3F, '0);
		chk(rv, 32'h0000_0000);
		// table rows: fresh reset, enter the mode, read one location
		foreach (ROWS[i]) begin
			ahb(1'b1, REG_CFG, {31'h0, ROWS[i].bm});
			run_op(OP_RESET, '0, '0);
			run_op(ROWS[i].op, '0, '0);
			chk_arr(ROWS[i].a, ROWS[i].e);
		end
		ahb(1'b1, REG_CFG, '0);
		run_op(OP_RESET, '0, '0);
		// programming only clears bits; a second program cannot set them
		run_op(OP_PROGRAM, 21'h10, 16'h1234);
		chk_arr(21'h10, 16'h1234);
		run_op(OP_PROGRAM, 21'h10, 16'hFF00);
		chk_arr(21'h10, 16'h1200);
		run_op(OP_AUTOSEL, '0, '0);
		run_op(OP_RESET, '0, '0);
		chk_arr(21'h10, 16'h1200);
		// bypass: enter, short program, plain reset refused, two-cycle exit
		run_op(OP_BYP_ENTER, '0, '0);
		chk_st(32'h0000_0024);
		run_op(OP_BYP_PROGRAM, 21'h20, 16'h00E0);
		run_op(OP_RESET, '0, '0);
		chk_st(32'h0000_00A4);
		ahb(1'b1, REG_STATUS, 32'h0000_0080);
		run_op(OP_BYP_EXIT, '0, '0);
		chk_arr(21'h20, 16'h00E0);
		chk_st(32'h0000_0004);
		// time-limit fault: the controller must recover with a reset write
		fail <= 1'b1;
		run_op(OP_PROGRAM, 21'h30, 16'h0000);
		chk_st(32'h0000_0006);
		fail <= 1'b0;
		ahb(1'b1, REG_STATUS, 32'h0000_0002);
		chk_arr(21'h30, 16'hFFFF);
		// low supply: the op is refused and never reaches the pins
		supply_low <= 1'b1;
		run_op(OP_PROGRAM, 21'h40, 16'h0000);
		chk_st(32'h0000_0184);
		supply_low <= 1'b0;
		ahb(1'b1, REG_STATUS, 32'h0000_0080);
		chk_arr(21'h40, 16'hFFFF);
		print_verdict();
	end
endmodule // flc_ctrl_tb
